// File: dpc_top.sv
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "dpc_defines.svh"

module dpc_top
(
   // clock and reset
   input  wire logic        clock,
   input  wire logic        rst,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // drive state
   input  wire logic        fieldbus_mode,
   input  wire logic [31:0] motor_position,
   // shared limit switch / capture pins
   input  wire logic        positive_limit_switch_input,
   input  wire logic        negative_limit_switch_input,
   // interrupt
   output logic             irq
);

   dpc_pkg::dpc_ctrl_t   ctrl_a;
   dpc_pkg::dpc_ctrl_t   ctrl_b;
   dpc_pkg::dpc_result_t res_a;
   dpc_pkg::dpc_result_t res_b;
   logic                 capture_a_edge_select;
   logic                 capture_b_edge_select;
   logic [1:0]           capture_a_arm_select;
   logic [1:0]           capture_b_arm_select;
   logic [2:0]           status_reg;
   logic [2:0]           mask_reg;
   logic [2:0]           status_next;
   logic [2:0]           mask_next;
   logic                 wr;
   logic                 rd;
   logic                 arm_a_wr;
   logic                 arm_b_wr;
   logic                 arm_code_ok;
   logic                 refused;

   // ==========================================================
   // apb decode: one wait state, two access phase cycles
   assign wr = psel && penable && pwrite && !pready;
   assign rd = psel && penable && !pwrite && !pready;
   assign arm_code_ok = pwdata[1:0] == `DPC_ARM_STOP ||
                        pwdata[1:0] == `DPC_ARM_ONCE ||
                        pwdata[1:0] == `DPC_ARM_CONT;

   // stop is always honoured; starts need fieldbus mode
   assign arm_a_wr = wr && paddr == `DPC_OFS_A_ARM && arm_code_ok &&
                     (fieldbus_mode ||
                      pwdata[1:0] == `DPC_ARM_STOP);
   assign arm_b_wr = wr && paddr == `DPC_OFS_B_ARM && arm_code_ok &&
                     (fieldbus_mode ||
                      pwdata[1:0] == `DPC_ARM_STOP);
   assign refused  = wr && arm_code_ok && !fieldbus_mode &&
                     pwdata[1:0] != `DPC_ARM_STOP &&
                     (paddr == `DPC_OFS_A_ARM ||
                      paddr == `DPC_OFS_B_ARM);

   assign ctrl_a = '{arm_write: arm_a_wr, arm_code: pwdata[1:0],
                     edge_rise: capture_a_edge_select};
   assign ctrl_b = '{arm_write: arm_b_wr, arm_code: pwdata[1:0],
                     edge_rise: capture_b_edge_select};

   // ==========================================================
   // two independent channels on the limit switch pins
   dpc_channel u_capture_input_a
   (
      .clock          (clock),
      .rst            (rst),
      .pin_in         (positive_limit_switch_input),
      .motor_position (motor_position),
      .ctrl           (ctrl_a),
      .result         (res_a)
   );

   dpc_channel u_capture_input_b
   (
      .clock          (clock),
      .rst            (rst),
      .pin_in         (negative_limit_switch_input),
      .motor_position (motor_position),
      .ctrl           (ctrl_b),
      .result         (res_b)
   );

   // ==========================================================
   // settings registers
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         capture_a_edge_select <= `DPC_EDGE_FALL;
         capture_b_edge_select <= `DPC_EDGE_FALL;
         mask_reg              <= `DPC_ZERO_ST;
      end
      else if (wr)
      begin
         if (paddr == `DPC_OFS_A_EDGE)
            capture_a_edge_select <= pwdata[0];
         if (paddr == `DPC_OFS_B_EDGE)
            capture_b_edge_select <= pwdata[0];
         if (paddr == `DPC_OFS_MASK)
            mask_reg <= pwdata[2:0];
      end
   end

   // last accepted code while armed, stop once the channel disarms; shown on read
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         capture_a_arm_select <= `DPC_ARM_STOP;
         capture_b_arm_select <= `DPC_ARM_STOP;
      end
      else
      begin
         if (arm_a_wr)
            capture_a_arm_select <= pwdata[1:0];
         else if (!res_a.armed)
            capture_a_arm_select <= `DPC_ARM_STOP;
         if (arm_b_wr)
            capture_b_arm_select <= pwdata[1:0];
         else if (!res_b.armed)
            capture_b_arm_select <= `DPC_ARM_STOP;
      end
   end

   // irq must see a mask write in the same edge as the status it gates
   assign mask_next = (wr && paddr == `DPC_OFS_MASK) ? pwdata[2:0] :
                      mask_reg;

   // ==========================================================
   // sticky status, write one to clear; set wins over clear
   always_comb
   begin
      status_next = status_reg;
      if (wr && paddr == `DPC_OFS_STATUS)
         status_next = status_next & ~pwdata[2:0];
      if (res_a.event_pulse)
         status_next[`DPC_ST_CAP_A] = 1'b1;
      if (res_b.event_pulse)
         status_next[`DPC_ST_CAP_B] = 1'b1;
      if (refused)
         status_next[`DPC_ST_REFUSED] = 1'b1;
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         status_reg <= `DPC_ZERO_ST;
         irq        <= 1'b0;
      end
      else
      begin
         status_reg <= status_next;
         irq        <= |(status_next & mask_next);
      end
   end

   // ==========================================================
   // apb answer and read mux
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= `DPC_ZERO32;
      end
      else
      begin
         pready  <= psel && penable && !pready;
         pslverr <= 1'b0;
         prdata  <= `DPC_ZERO32;
         if (psel && penable && !pready)
         begin
            unique case (paddr)
               `DPC_OFS_A_ARM, `DPC_OFS_B_ARM:
                  pslverr <= pwrite && !(arm_code_ok && !refused);
               `DPC_OFS_A_EDGE, `DPC_OFS_B_EDGE, `DPC_OFS_STATUS,
               `DPC_OFS_MASK:
                  pslverr <= 1'b0;
               `DPC_OFS_A_COUNT, `DPC_OFS_B_COUNT, `DPC_OFS_A_POS,
               `DPC_OFS_B_POS, `DPC_OFS_ARMED:
                  pslverr <= pwrite;
               default:
                  pslverr <= 1'b1;
            endcase
         end
         if (rd)
         begin
            unique case (paddr)
               `DPC_OFS_A_ARM:   prdata[1:0]  <= capture_a_arm_select;
               `DPC_OFS_B_ARM:   prdata[1:0]  <= capture_b_arm_select;
               `DPC_OFS_A_EDGE:  prdata[0]    <= capture_a_edge_select;
               `DPC_OFS_B_EDGE:  prdata[0]    <= capture_b_edge_select;
               `DPC_OFS_A_COUNT: prdata[15:0] <= res_a.count;
               `DPC_OFS_B_COUNT: prdata[15:0] <= res_b.count;
               `DPC_OFS_A_POS:   prdata       <= res_a.position;
               `DPC_OFS_B_POS:   prdata       <= res_b.position;
               `DPC_OFS_STATUS:  prdata[2:0]  <= status_reg;
               `DPC_OFS_MASK:    prdata[2:0]  <= mask_reg;
               `DPC_OFS_ARMED:   prdata[1:0]  <= {res_b.armed,
                                                  res_a.armed};
               default:          prdata       <= `DPC_ZERO32;
            endcase
         end
      end
   end

   a_refuse_mode: assert property (@(posedge clock) disable iff (rst)
      (wr && !fieldbus_mode && paddr == `DPC_OFS_A_ARM && !res_a.armed &&
       pwdata[1:0] == `DPC_ARM_ONCE) |=> !res_a.armed)
      else $error("activation accepted outside fieldbus mode");
   a_refuse_b: assert property (@(posedge clock) disable iff (rst)
      (wr && !fieldbus_mode && paddr == `DPC_OFS_B_ARM && !res_b.armed &&
       pwdata[1:0] == `DPC_ARM_CONT) |=> !res_b.armed)
      else $error("channel b armed outside fieldbus mode");
   a_refuse_flag: assert property (@(posedge clock) disable iff (rst)
      refused |=> status_reg[`DPC_ST_REFUSED])
      else $error("refused activation not flagged");
   a_cap_status: assert property (@(posedge clock) disable iff (rst)
      res_a.event_pulse |=> status_reg[`DPC_ST_CAP_A])
      else $error("capture a not flagged in status");
   a_pready_pulse: assert property (@(posedge clock) disable iff (rst)
      pready |=> !pready)
      else $error("pready stood longer than one cycle");
   a_arm_once: assert property (@(posedge clock) disable iff (rst)
      arm_a_wr && pwdata[1:0] == `DPC_ARM_ONCE |=> res_a.armed)
      else $error("write of one did not arm");
   a_arm_cont: assert property (@(posedge clock) disable iff (rst)
      arm_b_wr && pwdata[1:0] == `DPC_ARM_CONT |=> res_b.armed)
      else $error("write of two did not arm");
   a_irq_level: assert property (@(posedge clock) disable iff (rst)
      ##1 irq == |(status_reg & mask_reg))
      else $error("interrupt does not follow status and mask");

   c_refused: cover property (@(posedge clock) refused);
   c_both: cover property (@(posedge clock)
      res_a.event_pulse && res_b.event_pulse);

endmodule : dpc_top

// File: dpc_defines.svh
// Overview of operation
// - latch motor position on valid armed trigger
// - two independent inputs on limit switch pins
// - per input: one-time or continuous capture
// - one-time captures first qualifying edge after arming
// - one-time disarms itself after capture
// - continuous recaptures every qualifying edge, stays armed
// - edge polarity selectable rising or falling
// - writing 1 arms one-time capture
// - writing 2 arms continuous capture
// - writing 0 disarms the input
// - arm select coding: 0 stop, 1 once, 2 continuous
// - edge coding: 0 falling, 1 rising
// - event counter cleared on each activation
// - activation accepted only in fieldbus control mode
`ifndef DPC_DEFINES_SVH
`define DPC_DEFINES_SVH

// ==========================================================
// register byte offsets
`define DPC_OFS_A_ARM     12'h000
`define DPC_OFS_A_EDGE    12'h004
`define DPC_OFS_A_COUNT   12'h008
`define DPC_OFS_A_POS     12'h00C
`define DPC_OFS_B_ARM     12'h010
`define DPC_OFS_B_EDGE    12'h014
`define DPC_OFS_B_COUNT   12'h018
`define DPC_OFS_B_POS     12'h01C
`define DPC_OFS_STATUS    12'h020
`define DPC_OFS_MASK      12'h024
`define DPC_OFS_ARMED     12'h028

// ==========================================================
// field codes
`define DPC_ARM_STOP      2'h0
`define DPC_ARM_ONCE      2'h1
`define DPC_ARM_CONT      2'h2
`define DPC_EDGE_FALL     1'h0
`define DPC_EDGE_RISE     1'h1

// ==========================================================
// status bits: capture a, capture b, refused activation
`define DPC_ST_CAP_A      0
`define DPC_ST_CAP_B      1
`define DPC_ST_REFUSED    2
`define DPC_ST_W          3

`define DPC_ZERO32        32'h0000_0000
`define DPC_ZERO16        16'h0000
`define DPC_ONE16         16'h0001
`define DPC_ZERO_ST       3'h0

`endif

// File: dpc_pkg.sv
package dpc_pkg;

   // ==========================================================
   // capture channel states
   typedef enum logic [2:0] {
      DPC_IDLE = 3'b001,
      DPC_ONCE = 3'b010,
      DPC_CONT = 3'b100
   } dpc_state_t;

   // ==========================================================
   // results of one channel
   typedef struct packed {
      logic [31:0] position;
      logic [15:0] count;
      logic        event_pulse;
      logic        armed;
   } dpc_result_t;

   // ==========================================================
   // commands to one channel
   typedef struct packed {
      logic       arm_write;
      logic [1:0] arm_code;
      logic       edge_rise;
   } dpc_ctrl_t;

endpackage : dpc_pkg

// File: dpc_sync.sv
`timescale 1ns/1ps

module dpc_sync
(
   // clock and reset
   input  wire logic clock,
   input  wire logic rst,
   // pin
   input  wire logic pin_in,
   // synchronised level
   output logic      level_out
);

   logic meta_reg;

   // ==========================================================
   // two stage synchroniser; meta_reg feeds level_out only
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         meta_reg  <= 1'b0;
         level_out <= 1'b0;
      end
      else
      begin
         meta_reg  <= pin_in;
         level_out <= meta_reg;
      end
   end

endmodule : dpc_sync

// File: dpc_channel.sv
`timescale 1ns/1ps
`include "dpc_defines.svh"

module dpc_channel
(
   // clock and reset
   input  wire logic                   clock,
   input  wire logic                   rst,
   // pin and position
   input  wire logic                   pin_in,
   input  wire logic [31:0]            motor_position,
   // control
   input  wire dpc_pkg::dpc_ctrl_t     ctrl,
   // result
   output dpc_pkg::dpc_result_t        result
);

   logic                level;
   logic                level_d_reg;
   logic                edge_hit;
   dpc_pkg::dpc_state_t state_reg;
   logic                edge_rise_reg;

   dpc_sync u_sync
   (
      .clock     (clock),
      .rst       (rst),
      .pin_in    (pin_in),
      .level_out (level)
   );

   // ==========================================================
   // edge detection on the synchronised level
   always_ff @(posedge clock)
   begin
      if (rst)
         level_d_reg <= 1'b0;
      else
         level_d_reg <= level;
   end

   assign edge_hit = (edge_rise_reg == `DPC_EDGE_RISE) ?
                     (level & ~level_d_reg) : (~level & level_d_reg);

   always_ff @(posedge clock)
   begin
      if (rst)
         edge_rise_reg <= `DPC_EDGE_FALL;
      else if (ctrl.arm_write)
         edge_rise_reg <= ctrl.edge_rise;
   end

   // ==========================================================
   // arming state; a fresh arm write wins over a pending edge
   always_ff @(posedge clock)
   begin
      if (rst)
         state_reg <= dpc_pkg::DPC_IDLE;
      else if (ctrl.arm_write)
      begin
         unique case (ctrl.arm_code)
            `DPC_ARM_ONCE: state_reg <= dpc_pkg::DPC_ONCE;
            `DPC_ARM_CONT: state_reg <= dpc_pkg::DPC_CONT;
            default:       state_reg <= dpc_pkg::DPC_IDLE;
         endcase
      end
      else
      begin
         unique case (state_reg)
            dpc_pkg::DPC_ONCE:
               if (edge_hit)
                  state_reg <= dpc_pkg::DPC_IDLE;
            dpc_pkg::DPC_CONT: state_reg <= dpc_pkg::DPC_CONT;
            dpc_pkg::DPC_IDLE: state_reg <= dpc_pkg::DPC_IDLE;
            default:           state_reg <= dpc_pkg::DPC_IDLE;
         endcase
      end
   end

   logic capture;
   assign capture = edge_hit && !ctrl.arm_write &&
                    (state_reg != dpc_pkg::DPC_IDLE);

   // ==========================================================
   // latched position, counter, event pulse
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         result <= '0;
      end
      else
      begin
         result.event_pulse <= capture;
         result.armed <= ctrl.arm_write ?
                         (ctrl.arm_code == `DPC_ARM_ONCE ||
                          ctrl.arm_code == `DPC_ARM_CONT) :
                         (state_reg != dpc_pkg::DPC_IDLE &&
                          !(state_reg == dpc_pkg::DPC_ONCE && edge_hit));
         if (ctrl.arm_write && ctrl.arm_code != `DPC_ARM_STOP)
            result.count <= `DPC_ZERO16;
         else if (capture)
            result.count <= result.count + `DPC_ONE16;
         if (capture)
            result.position <= motor_position;
      end
   end

   a_once_disarms: assert property (@(posedge clock) disable iff (rst)
      (state_reg == dpc_pkg::DPC_ONCE && edge_hit && !ctrl.arm_write)
      |=> state_reg == dpc_pkg::DPC_IDLE)
      else $error("one-time capture stayed armed");
   a_cont_stays: assert property (@(posedge clock) disable iff (rst)
      (state_reg == dpc_pkg::DPC_CONT && !ctrl.arm_write)
      |=> state_reg == dpc_pkg::DPC_CONT)
      else $error("continuous capture lost arming");
   a_pos_latched: assert property (@(posedge clock) disable iff (rst)
      capture |=> result.position == $past(motor_position))
      else $error("position not latched");
   a_idle_no_cap: assert property (@(posedge clock) disable iff (rst)
      (state_reg == dpc_pkg::DPC_IDLE) |=> !result.event_pulse)
      else $error("capture while disarmed");
   a_stop_disarms: assert property (@(posedge clock) disable iff (rst)
      (ctrl.arm_write && ctrl.arm_code == `DPC_ARM_STOP)
      |=> state_reg == dpc_pkg::DPC_IDLE)
      else $error("stop did not disarm");
   a_count_clear: assert property (@(posedge clock) disable iff (rst)
      (ctrl.arm_write && ctrl.arm_code != `DPC_ARM_STOP)
      |=> result.count == `DPC_ZERO16)
      else $error("counter not cleared on activation");
   a_edge_polarity: assert property (@(posedge clock) disable iff (rst)
      capture |-> (level != level_d_reg && level == edge_rise_reg))
      else $error("capture on wrong edge");
   a_count_step: assert property (@(posedge clock) disable iff (rst)
      (capture && !ctrl.arm_write)
      |=> result.count == $past(result.count) + `DPC_ONE16)
      else $error("counter did not advance");

   c_once: cover property (@(posedge clock)
      state_reg == dpc_pkg::DPC_ONCE && capture);
   c_cont_two: cover property (@(posedge clock)
      state_reg == dpc_pkg::DPC_CONT && capture ##[1:50] capture);
   c_fall: cover property (@(posedge clock)
      capture && !edge_rise_reg);

endmodule : dpc_channel

// File: dpc_pin_model.sv
`timescale 1ns/1ps

module dpc_pin_model
(
   // clock and reset
   input  wire logic       clock,
   input  wire logic       rst,
   // flip requests; slow delays the flip by four cycles
   input  wire logic [1:0] flip_req,
   input  wire logic       slow,
   // capture pins
   output logic            positive_limit_switch_input,
   output logic            negative_limit_switch_input
);
   logic [1:0] pend_reg;
   logic [2:0] wait_reg;

   // ==========================================
   // pin levels, each flipped on its own request
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         pend_reg                    <= 2'h0;
         wait_reg                    <= 3'h0;
         positive_limit_switch_input <= 1'b0;
         negative_limit_switch_input <= 1'b0;
      end
      else if (flip_req != 2'h0)
      begin
         pend_reg <= flip_req;
         wait_reg <= slow ? 3'h4 : 3'h0;
      end
      else if (wait_reg != 3'h0)
         wait_reg <= wait_reg - 3'h1;
      else if (pend_reg != 2'h0)
      begin
         // pins are separate wires
         positive_limit_switch_input <= positive_limit_switch_input ^ pend_reg[0];
         negative_limit_switch_input <= negative_limit_switch_input ^ pend_reg[1];
         pend_reg                    <= 2'h0;
      end
   end
endmodule : dpc_pin_model

// File: testbench.sv
`timescale 1ns/1ps
`include "dpc_defines.svh"

module testbench;
   logic        clock;
   logic        rst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        fieldbus_mode;
   logic [31:0] motor_position;
   logic        pin_a;
   logic        pin_b;
   logic        irq;
   logic [1:0]  flip_req;
   logic        slow;
   logic [33:0] exp_q[$];
   logic [33:0] note;
   logic [31:0] pos_a;
   logic [31:0] pos_b;
   int          n_fail;
   int          samples_checked;
   int          seed_word;

   dpc_top dpc_top_inst (.clock(clock), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fieldbus_mode(fieldbus_mode), .motor_position(motor_position),
      .positive_limit_switch_input(pin_a),
      .negative_limit_switch_input(pin_b), .irq(irq));

   dpc_pin_model dpc_pin_model_inst (.clock(clock), .rst(rst),
      .flip_req(flip_req), .slow(slow),
      .positive_limit_switch_input(pin_a),
      .negative_limit_switch_input(pin_b));

   initial
   begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   // ==========================================
   // compare and report
   task check_word(input string what, input logic [31:0] exp,
                   input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check_word

   task check_bit(input string what, input logic exp, input logic got);
      samples_checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
      end
   endtask : check_bit

   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : tally_and_finish

   // ==========================================
   // drivers; d is write data or expected read data
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
            input logic err);
      int n;
      n = 0;
      @(posedge clock);
      exp_q.push_back({~wr, err, d});
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= wr ? d : 32'h0000_0000;
      @(posedge clock);
      penable <= 1'b1;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         check_bit("pready", 1'b1, pready);
         tally_and_finish();
      end
      else
      begin
         psel    <= 1'b0;
         penable <= 1'b0;
      end
   endtask : apb

   // position is held steady across the capture latency
   task edge_on(input logic [1:0] which, input logic slow_i,
                input logic [31:0] pos);
      @(posedge clock);
      motor_position <= pos;
      flip_req       <= which;
      slow           <= slow_i;
      @(posedge clock);
      flip_req <= 2'h0;
      repeat (14) @(posedge clock);
   endtask : edge_on

   task irq_after(input logic [11:0] a, input logic [31:0] d,
                  input logic exp);
      apb(1'b1, a, d, 1'b0);
      repeat (3) @(posedge clock);
      check_bit("irq", exp, irq);
   endtask : irq_after

   // ==========================================
   // answer monitor
   always @(posedge clock)
   begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1)
      begin
         if (exp_q.size() == 0)
            check_bit("spare answer", 1'b0, 1'b1);
         else
         begin
            note = exp_q.pop_front();
            check_bit("pslverr", note[32], pslverr);
            if (note[33] && !note[32])
               check_word("prdata", note[31:0], prdata);
         end
      end
   end

   initial
   begin
      repeat (60000) @(posedge clock);
      check_bit("watchdog", 1'b0, 1'b1);
      tally_and_finish();
   end

   // ==========================================
   // main sequence
   initial
   begin
      n_fail = 0;
      samples_checked = 0;
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      fieldbus_mode = 1'b0;
      motor_position = 32'h0000_0000;
      flip_req = 2'h0;
      slow = 1'b0;
      seed_word = $urandom(32'hF73C);
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      for (int i = 0; i < 11; i++)
         apb(1'b0, 12'(4 * i), 32'h0, 1'b0);
      apb(1'b0, 12'h030, 32'h0, 1'b1);
      apb(1'b1, `DPC_OFS_A_COUNT, 32'h1, 1'b1);
      apb(1'b1, `DPC_OFS_A_ARM, 32'h1, 1'b1);
      apb(1'b0, `DPC_OFS_ARMED, 32'h0, 1'b0);
      apb(1'b0, `DPC_OFS_STATUS, 32'h4, 1'b0);
      apb(1'b1, `DPC_OFS_STATUS, 32'h4, 1'b0);
      apb(1'b0, `DPC_OFS_STATUS, 32'h0, 1'b0);
      fieldbus_mode <= 1'b1;
      apb(1'b1, `DPC_OFS_A_ARM, 32'h3, 1'b1);
      apb(1'b0, `DPC_OFS_ARMED, 32'h0, 1'b0);
      // channel a: one-time, falling edge
      apb(1'b1, `DPC_OFS_A_EDGE, 32'h0, 1'b0);
      apb(1'b1, `DPC_OFS_A_ARM, 32'h1, 1'b0);
      apb(1'b0, `DPC_OFS_ARMED, 32'h1, 1'b0);
      pos_a = $urandom;
      edge_on(2'b01, 1'b0, ~pos_a);
      edge_on(2'b01, 1'b1, pos_a);
      edge_on(2'b01, 1'b0, $urandom);
      edge_on(2'b01, 1'b0, $urandom);
      apb(1'b0, `DPC_OFS_A_POS, pos_a, 1'b0);
      apb(1'b0, `DPC_OFS_A_COUNT, 32'h1, 1'b0);
      apb(1'b0, `DPC_OFS_ARMED, 32'h0, 1'b0);
      apb(1'b0, `DPC_OFS_B_POS, 32'h0, 1'b0);
      // channel b: continuous, rising edge
      apb(1'b1, `DPC_OFS_B_EDGE, 32'h1, 1'b0);
      apb(1'b1, `DPC_OFS_B_ARM, 32'h2, 1'b0);
      for (int k = 1; k <= 3; k++)
      begin
         pos_b = $urandom;
         edge_on(2'b10, k[0], pos_b);
         apb(1'b0, `DPC_OFS_B_POS, pos_b, 1'b0);
         apb(1'b0, `DPC_OFS_B_COUNT, 32'(k), 1'b0);
         edge_on(2'b10, 1'b0, ~pos_b);
      end
      apb(1'b0, `DPC_OFS_ARMED, 32'h2, 1'b0);
      apb(1'b1, `DPC_OFS_B_ARM, 32'h0, 1'b0);
      edge_on(2'b10, 1'b0, $urandom);
      apb(1'b0, `DPC_OFS_B_POS, pos_b, 1'b0);
      apb(1'b0, `DPC_OFS_ARMED, 32'h0, 1'b0);
      apb(1'b1, `DPC_OFS_B_ARM, 32'h1, 1'b0);
      apb(1'b0, `DPC_OFS_B_COUNT, 32'h0, 1'b0);
      // interrupt: both capture bits pending, mask clear
      apb(1'b0, `DPC_OFS_STATUS, 32'h3, 1'b0);
      check_bit("irq", 1'b0, irq);
      irq_after(`DPC_OFS_MASK, 32'h2, 1'b1);
      irq_after(`DPC_OFS_STATUS, 32'h2, 1'b0);
      irq_after(`DPC_OFS_MASK, 32'h3, 1'b1);
      irq_after(`DPC_OFS_STATUS, 32'h1, 1'b0);
      tally_and_finish();
   end
endmodule : testbench
